/* rtl/device_state_control_regs.sv */
// device state control registers with power state, button and pin handling
`default_nettype none
module device_state_control_regs
  import dev_state_pkg::*;
#(
  parameter int SLOT_A     = SLOT_200US_CYC,
  parameter int SLOT_B     = SLOT_500US_CYC,
  parameter int SLOT_C     = SLOT_2MS_CYC,
  parameter int LONG_PRESS = LONG_PRESS_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // boot configuration and backup entry
  input  wire logic       boot_load,
  input  wire logic       boot_stay_on,
  input  wire logic [1:0] boot_slot_duration,
  input  wire logic       boot_hold_shutdown_en,
  input  wire logic       boot_hold_core_reset_en,
  input  wire logic       boot_irq_pol,
  input  wire logic       backup_rst,
  // device events
  input  wire logic       power_on_event,
  input  wire logic       ext_off_event,
  input  wire logic       irq_req,
  // pins
  input  wire logic       sleep_pin,
  input  wire logic       power_button_pin,
  output logic            irq_out_pin,
  // serial port scaling access
  input  wire logic [7:0] ctl_port_addr,
  input  wire logic [7:0] scale_port_addr,
  output logic            ctl_scale_grant,
  output logic            scale_port_grant,
  // controls to the rest of the device
  output logic      [3:0] res_en,
  output logic            core_rst_pulse,
  output logic            cal_clk_en,
  output logic            cal_rst,
  output logic            slow_clk_rc_sel,
  output logic            buck_use_sleep_level,
  output logic      [1:0] dev_state
);
  typedef enum logic [2:0] {st_off, st_up, st_active, st_sleep, st_down} pwr_state_e;

  function automatic logic is_scaling_reg(input logic [7:0] a);
    is_scaling_reg = (a == ADDR_CORE_A_OP) || (a == ADDR_CORE_A_SLP)
                  || (a == ADDR_CORE_B_OP) || (a == ADDR_CORE_B_SLP)
                  || (a == ADDR_EXT_BUCK_OP) || (a == ADDR_EXT_BUCK_SLP);
  endfunction

  pwr_state_e             state_r;
  pwr_state_e             state_nxt;
  logic [7:0]             ctrl_r;
  logic [7:0]             ctrl2_r;
  logic [7:0]             rdata_r;
  logic [1:0]             slp_sync_r;
  logic [1:0]             btn_sync_r;
  logic [PRESS_CNT_W-1:0] press_cnt_r;
  logic                   press_done_r;
  logic                   lp_hit;
  logic                   irq_r;
  logic                   core_rst_r;
  logic                   rst_pending_r;
  logic                   cal_clk_en_r;
  logic                   cal_rst_r;
  logic                   ctl_grant_r;
  logic                   scale_grant_r;
  logic                   wr_ctrl;
  logic                   wr_ctrl2;
  logic                   sleep_req;
  logic                   off_bits;
  logic                   in_off;
  logic                   shutdown_evt;
  seq_if                  sq ();

  assign wr_ctrl  = reg_wr && reg_addr == ADDR_DEV_CTRL;
  assign wr_ctrl2 = reg_wr && reg_addr == ADDR_DEV_CTRL_TWO;
  assign off_bits = ctrl_r[BIT_SWITCH_OFF] | ctrl_r[BIT_OFF_CORE_RESET];
  assign in_off   = state_r == st_off;

  // first control register; hardware clear in off loses to a same-cycle write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= DEV_CTRL_RST;
    end else if (boot_load) begin
      ctrl_r[BIT_STAY_ON] <= boot_stay_on;
    end else if (backup_rst) begin
      ctrl_r <= (DEV_CTRL_RST & ~(8'h01 << BIT_CAL_POWERDOWN))
              | (ctrl_r & (8'h01 << BIT_CAL_POWERDOWN));
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata;
    end else if (in_off) begin
      ctrl_r[BIT_SWITCH_OFF]     <= 1'b0;
      ctrl_r[BIT_OFF_CORE_RESET] <= 1'b0;
      ctrl_r[BIT_SLEEP_ALLOW]    <= 1'b0;
    end
  end

  // second control register, bit 7 reserved and read as zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl2_r <= DEV_CTRL_TWO_RST;
    end else if (boot_load) begin
      ctrl2_r[BIT_SLOT_HI:BIT_SLOT_LO] <= boot_slot_duration;
      ctrl2_r[BIT_HOLD_SHUTDOWN]       <= boot_hold_shutdown_en;
      ctrl2_r[BIT_HOLD_CORE_RESET]     <= boot_hold_core_reset_en;
      ctrl2_r[BIT_IRQ_POL]             <= boot_irq_pol;
    end else if (backup_rst) begin
      ctrl2_r <= DEV_CTRL_TWO_RST;
    end else if (wr_ctrl2) begin
      ctrl2_r <= reg_wdata & DEV_CTRL_TWO_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_DEV_CTRL:     rdata_r <= ctrl_r;
        ADDR_DEV_CTRL_TWO: rdata_r <= ctrl2_r;
        default:           rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end
  assign reg_rdata = rdata_r;

  // pins pass two flops before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slp_sync_r <= '0;
      btn_sync_r <= 2'h3;
    end else begin
      slp_sync_r <= {slp_sync_r[0], sleep_pin};
      btn_sync_r <= {btn_sync_r[0], power_button_pin};
    end
  end

  assign sleep_req = ctrl2_r[BIT_SLEEP_PIN_POL] ? slp_sync_r[1] : ~slp_sync_r[1];

  // long press: button low for the full count, one hit per press
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      press_cnt_r  <= '0;
      press_done_r <= 1'b0;
    end else if (btn_sync_r[1]) begin
      press_cnt_r  <= '0;
      press_done_r <= 1'b0;
    end else if (lp_hit) begin
      press_done_r <= 1'b1;
    end else if (!press_done_r) begin
      press_cnt_r <= press_cnt_r + 1'b1;
    end
  end
  assign lp_hit = !btn_sync_r[1] && !press_done_r
               && press_cnt_r == PRESS_CNT_W'(LONG_PRESS - 1);

  // stay-on masks only ext_off_event; off bits and a long-press shutdown are never masked
  assign shutdown_evt = off_bits
                      || (lp_hit && ctrl2_r[BIT_HOLD_SHUTDOWN])
                      || (ext_off_event && !ctrl_r[BIT_STAY_ON]);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_off:    if (power_on_event) state_nxt = st_up;
      st_up:     if (sq.done) state_nxt = st_active;
      st_active: begin
        if (shutdown_evt) begin
          state_nxt = st_down;
        end else if (ctrl_r[BIT_SLEEP_ALLOW] && sleep_req) begin
          state_nxt = st_sleep;
        end
      end
      st_sleep: begin
        if (shutdown_evt) begin
          state_nxt = st_down;
        end else if (!ctrl_r[BIT_SLEEP_ALLOW] || !sleep_req) begin
          state_nxt = st_active;
        end
      end
      st_down:   if (sq.done) state_nxt = st_off;
      default:   state_nxt = st_off;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= st_off;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sq.start_up   = in_off && power_on_event;
  assign sq.start_down = (state_r == st_active || state_r == st_sleep) && shutdown_evt;
  assign sq.ordered    = ctrl_r[BIT_ORDERED_SHUTDOWN];
  assign sq.slot_sel   = ctrl2_r[BIT_SLOT_HI:BIT_SLOT_LO];

  slot_sequencer #(
    .SLOT_A (SLOT_A),
    .SLOT_B (SLOT_B),
    .SLOT_C (SLOT_C)
  ) u_seq (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sq      (sq)
  );

  // core reset fires when the off state is reached after an off-with-reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pending_r <= 1'b0;
      core_rst_r    <= 1'b0;
    end else begin
      core_rst_r <= 1'b0;
      if (sq.start_down) begin
        rst_pending_r <= ctrl_r[BIT_OFF_CORE_RESET];
      end
      if (state_r == st_down && sq.done && rst_pending_r) begin
        core_rst_r    <= 1'b1;
        rst_pending_r <= 1'b0;
      end else if (in_off && lp_hit && ctrl2_r[BIT_HOLD_CORE_RESET]) begin
        core_rst_r <= 1'b1;
      end
    end
  end

  // registered pin and control outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_r         <= 1'b1;
      cal_clk_en_r  <= 1'b1;
      cal_rst_r     <= 1'b0;
      ctl_grant_r   <= 1'b0;
      scale_grant_r <= 1'b0;
    end else begin
      irq_r         <= ctrl2_r[BIT_IRQ_POL] ? irq_req : ~irq_req;
      cal_clk_en_r  <= ~ctrl_r[BIT_CAL_POWERDOWN];
      cal_rst_r     <= ctrl_r[BIT_CAL_POWERDOWN];
      ctl_grant_r   <= ctrl_r[BIT_SCALING_PORT] && is_scaling_reg(ctl_port_addr);
      scale_grant_r <= !ctrl_r[BIT_SCALING_PORT] && is_scaling_reg(scale_port_addr);
    end
  end

  assign irq_out_pin          = irq_r;
  assign cal_clk_en           = cal_clk_en_r;
  assign cal_rst              = cal_rst_r;
  assign ctl_scale_grant      = ctl_grant_r;
  assign scale_port_grant     = scale_grant_r;
  assign core_rst_pulse       = core_rst_r;
  assign res_en               = sq.res_en;
  assign slow_clk_rc_sel      = ctrl_r[BIT_SLOW_CLK_SEL];
  // converter picks its sleep-voltage register only in sleep; value must be nonzero
  assign buck_use_sleep_level = ctrl2_r[BIT_SLEEP_LEVEL_EN] && state_r == st_sleep;
  assign dev_state = (state_r == st_off) ? 2'h0 : (state_r == st_sleep) ? 2'h2 :
                     (state_r == st_active) ? 2'h1 : 2'h3;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_off_clears_req: assert property (
    in_off && !wr_ctrl && !boot_load && !backup_rst |=> !ctrl_r[BIT_SWITCH_OFF])
    else $error("switch-off request not cleared in off state");
  a_off_rst_done: assert property (
    state_r == st_down && sq.done && rst_pending_r |=> core_rst_r && state_r == st_off)
    else $error("core reset missing on reaching off");
  a_sleep_clears: assert property (
    in_off && !wr_ctrl && !boot_load |=> !ctrl_r[BIT_SLEEP_ALLOW])
    else $error("sleep allow not cleared in off state");
  a_wake_on_clear: assert property (
    state_r == st_sleep && !ctrl_r[BIT_SLEEP_ALLOW] && !shutdown_evt |=> state_r == st_active)
    else $error("no wake-up after sleep allow cleared");
  a_cal_backup: assert property (
    backup_rst && !boot_load |=> ctrl_r[BIT_CAL_POWERDOWN] == $past(ctrl_r[BIT_CAL_POWERDOWN]))
    else $error("calendar powerdown lost on backup entry");
  a_cal_gated: assert property (
    ctrl_r[BIT_CAL_POWERDOWN] |=> !cal_clk_en && cal_rst)
    else $error("calendar domain not gated");
  a_scale_route: assert property (
    ctl_scale_grant |-> !scale_port_grant && $past(ctrl_r[BIT_SCALING_PORT]))
    else $error("scaling access granted to wrong port");
  a_scale_six: assert property (
    scale_port_grant |-> $past(is_scaling_reg(scale_port_addr)))
    else $error("non-scaling register routed");
  a_sleep_pol: assert property (
    state_r == st_active ##1 state_r == st_sleep |-> $past(sleep_req))
    else $error("sleep entered without sleep request");
  a_stay_on: assert property (
    state_r == st_active && ctrl_r[BIT_STAY_ON] && !off_bits && !lp_hit |=> state_r != st_down)
    else $error("device left on-state despite stay-on");
  a_long_off: assert property (
    state_r == st_active && lp_hit && ctrl2_r[BIT_HOLD_SHUTDOWN] |=> state_r inside {st_down, st_off})
    else $error("long press did not switch off");
  a_long_rst: assert property (
    in_off && lp_hit && ctrl2_r[BIT_HOLD_CORE_RESET] |=> core_rst_r)
    else $error("long press core reset missing in off");
  a_irq_level: assert property (
    ##1 irq_out_pin == ($past(irq_req) ~^ $past(ctrl2_r[BIT_IRQ_POL])))
    else $error("interrupt pin polarity wrong");
  a_boot_load: assert property (
    boot_load |=> ctrl_r[BIT_STAY_ON] == $past(boot_stay_on)
      && ctrl2_r[BIT_SLOT_HI:BIT_SLOT_LO] == $past(boot_slot_duration))
    else $error("boot defaults not loaded");
  a_sleep_level: assert property (
    buck_use_sleep_level |-> state_r == st_sleep)
    else $error("sleep level used outside sleep");

  c_power_up: cover property (state_r == st_up ##1 state_r == st_active);
  c_sleep_wake: cover property (state_r == st_sleep ##1 state_r == st_active);
  c_ordered_off: cover property (sq.start_down && sq.ordered);
  c_long_press: cover property (lp_hit);
endmodule
`default_nettype wire

/* rtl/dev_state_pkg.sv */
// constants shared by the device state control registers and the slot sequencer
`default_nettype none
package dev_state_pkg;
  localparam logic [7:0] ADDR_DEV_CTRL     = 8'h3F;
  localparam logic [7:0] ADDR_DEV_CTRL_TWO = 8'h40;
  localparam logic [7:0] ADDR_CORE_A_OP    = 8'h22;
  localparam logic [7:0] ADDR_CORE_A_SLP   = 8'h23;
  localparam logic [7:0] ADDR_CORE_B_OP    = 8'h24;
  localparam logic [7:0] ADDR_CORE_B_SLP   = 8'h25;
  localparam logic [7:0] ADDR_EXT_BUCK_OP  = 8'h26;
  localparam logic [7:0] ADDR_EXT_BUCK_SLP = 8'h27;
  // first control register fields
  localparam int BIT_ORDERED_SHUTDOWN = 7;
  localparam int BIT_CAL_POWERDOWN    = 6;
  localparam int BIT_SLOW_CLK_SEL     = 5;
  localparam int BIT_SCALING_PORT     = 4;
  localparam int BIT_OFF_CORE_RESET   = 3;
  localparam int BIT_STAY_ON          = 2;
  localparam int BIT_SLEEP_ALLOW      = 1;
  localparam int BIT_SWITCH_OFF       = 0;
  // second control register fields
  localparam int BIT_SLEEP_LEVEL_EN   = 6;
  localparam int BIT_SLOT_HI          = 5;
  localparam int BIT_SLOT_LO          = 4;
  localparam int BIT_SLEEP_PIN_POL    = 3;
  localparam int BIT_HOLD_SHUTDOWN    = 2;
  localparam int BIT_HOLD_CORE_RESET  = 1;
  localparam int BIT_IRQ_POL          = 0;
  localparam logic [7:0] DEV_CTRL_RST     = 8'h10;
  localparam logic [7:0] DEV_CTRL_TWO_RST = 8'h34;
  localparam logic [7:0] DEV_CTRL_TWO_MASK = 8'h7F;
  localparam int NUM_RES = 4;
  // timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int SLOT_200US_NS   = 200000;
  localparam int SLOT_500US_NS   = 500000;
  localparam int SLOT_2MS_NS     = 2000000;
  localparam int LONG_PRESS_NS   = 8000000;
  localparam int SLOT_200US_CYC  = SLOT_200US_NS / CLK_PERIOD_NS;
  localparam int SLOT_500US_CYC  = SLOT_500US_NS / CLK_PERIOD_NS;
  localparam int SLOT_2MS_CYC    = SLOT_2MS_NS / CLK_PERIOD_NS;
  localparam int LONG_PRESS_CYC  = (LONG_PRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_CNT_W      = 17;
  localparam int PRESS_CNT_W     = 19;
endpackage
`default_nettype wire

/* rtl/seq_if.sv */
// handshake between the device state logic and the slot sequencer
`default_nettype none
interface seq_if;
  logic       start_up;
  logic       start_down;
  logic       ordered;
  logic [1:0] slot_sel;
  logic [3:0] res_en;
  logic       done;
  modport ctrl (output start_up, output start_down, output ordered, output slot_sel,
                input res_en, input done);
  modport seq  (input start_up, input start_down, input ordered, input slot_sel,
                output res_en, output done);
endinterface
`default_nettype wire

/* rtl/slot_sequencer.sv */
// walks the power resources on, or off when ordered, one time slot at a time; unordered off clears all at once
`default_nettype none
module slot_sequencer
  import dev_state_pkg::*;
#(
  parameter int SLOT_A = SLOT_200US_CYC,
  parameter int SLOT_B = SLOT_500US_CYC,
  parameter int SLOT_C = SLOT_2MS_CYC
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // control side
  seq_if.seq        sq
);
  logic [SLOT_CNT_W-1:0] cnt_r;
  logic [1:0]            idx_r;
  logic                  busy_r;
  logic                  up_r;
  logic [3:0]            res_r;
  logic                  done_r;
  logic [SLOT_CNT_W-1:0] slot_len;

  always_comb begin
    case (sq.slot_sel)
      2'h0:    slot_len = '0;
      2'h1:    slot_len = SLOT_CNT_W'(SLOT_A - 1);
      2'h2:    slot_len = SLOT_CNT_W'(SLOT_B - 1);
      default: slot_len = SLOT_CNT_W'(SLOT_C - 1);
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      idx_r  <= '0;
      busy_r <= 1'b0;
      up_r   <= 1'b0;
      res_r  <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (sq.start_up) begin
        busy_r <= 1'b1;
        up_r   <= 1'b1;
        idx_r  <= '0;
        cnt_r  <= slot_len;
      end else if (sq.start_down && !sq.ordered) begin
        res_r  <= '0;
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end else if (sq.start_down) begin
        busy_r <= 1'b1;
        up_r   <= 1'b0;
        idx_r  <= 2'(NUM_RES - 1);
        cnt_r  <= slot_len;
      end else if (busy_r) begin
        if (cnt_r != '0) begin
          cnt_r <= cnt_r - 1'b1;
        end else begin
          res_r[idx_r] <= up_r;
          cnt_r        <= slot_len;
          if ((up_r && idx_r == 2'(NUM_RES - 1)) || (!up_r && idx_r == 2'h0)) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end else if (up_r) begin
            idx_r <= idx_r + 1'b1;
          end else begin
            idx_r <= idx_r - 1'b1;
          end
        end
      end
    end
  end

  assign sq.res_en = res_r;
  assign sq.done   = done_r;

  a_down_at_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sq.start_down && !sq.ordered && !sq.start_up |=> res_r == '0 && done_r)
    else $error("simultaneous power-off left a resource enabled");
  a_slot_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    busy_r && sq.slot_sel == 2'h0 && cnt_r == '0 && !sq.start_up && !sq.start_down
      |=> cnt_r == '0)
    else $error("zero slot length produced a wait");
endmodule
`default_nettype wire

/* dv/device_state_control_regs_bench.sv */
// self-checking bench for the device state control registers
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module device_state_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dev_state_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n, reg_wr, reg_rd, boot_load, backup_rst, power_on_event, ext_off_event;
  logic        irq_req, sleep_pin, power_button_pin, irq_out_pin, ctl_scale_grant;
  logic        scale_port_grant, core_rst_pulse, cal_clk_en, cal_rst, slow_clk_rc_sel;
  logic        buck_use_sleep_level, seen, hit;
  logic        boot_stay_on, boot_hold_shutdown_en, boot_hold_core_reset_en, boot_irq_pol;
  logic [1:0]  boot_slot_duration, dev_state;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ctl_port_addr, scale_port_addr;
  logic [3:0]  res_en, nch;
  logic [15:0] trace;
  int          err_total, n_checks, gap;
  int          slot_cyc[4] = '{1, 3, 5, 8};
  // short slot and press counts keep the run brief
  device_state_control_regs #(.SLOT_A(3), .SLOT_B(5), .SLOT_C(8), .LONG_PRESS(10)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_load(boot_load),
    .boot_stay_on(boot_stay_on), .boot_slot_duration(boot_slot_duration),
    .boot_hold_shutdown_en(boot_hold_shutdown_en),
    .boot_hold_core_reset_en(boot_hold_core_reset_en), .boot_irq_pol(boot_irq_pol),
    .backup_rst(backup_rst), .power_on_event(power_on_event), .ext_off_event(ext_off_event),
    .irq_req(irq_req), .sleep_pin(sleep_pin), .power_button_pin(power_button_pin),
    .irq_out_pin(irq_out_pin), .ctl_port_addr(ctl_port_addr),
    .scale_port_addr(scale_port_addr), .ctl_scale_grant(ctl_scale_grant),
    .scale_port_grant(scale_port_grant), .res_en(res_en), .core_rst_pulse(core_rst_pulse),
    .cal_clk_en(cal_clk_en), .cal_rst(cal_rst), .slow_clk_rc_sel(slow_clk_rc_sel),
    .buck_use_sleep_level(buck_use_sleep_level), .dev_state(dev_state));
  always #10 clk_sys = ~clk_sys;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
    end
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys) begin
      reg_addr <= a;
      reg_rd <= 1'b1;
    end
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  // records each change of the enables and the spacing of the last two
  task automatic watch(input logic [1:0] st);
    logic [3:0] last;
    int g;
    trace = '0;
    nch = '0;
    seen = 1'b0;
    g = 0;
    last = res_en;
    for (int i = 0; i < 3000 && dev_state !== st; i++) begin
      @(posedge clk_sys);
      #1 g++;
      if (core_rst_pulse === 1'b1) seen = 1'b1;
      if (res_en !== last) begin
        trace = {trace[11:0], res_en};
        nch++;
        gap = g;
        g = 0;
        last = res_en;
      end
    end
    // a state that never arrives is a failure, not a silent fall-through
    if (dev_state !== st) begin
      err_total++;
      $display("[ERR] %0t state wait ran out", $time);
      conclude();
    end
  endtask
  task automatic pwr_up();
    @(posedge clk_sys) power_on_event <= 1'b1;
    @(posedge clk_sys) power_on_event <= 1'b0;
    watch(2'd1);
  endtask
  task automatic ext_off();
    @(posedge clk_sys) ext_off_event <= 1'b1;
    @(posedge clk_sys) ext_off_event <= 1'b0;
  endtask
  // holds the button well past the long-press count after the synchroniser
  task automatic press(output logic h);
    h = 1'b0;
    @(posedge clk_sys) power_button_pin <= 1'b0;
    repeat (40) begin
      @(posedge clk_sys);
      #1 if (core_rst_pulse === 1'b1) h = 1'b1;
    end
    @(posedge clk_sys) power_button_pin <= 1'b1;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, boot_load, backup_rst, power_on_event, ext_off_event} = '0;
    {irq_req, sleep_pin, boot_stay_on, boot_hold_shutdown_en} = '0;
    {boot_hold_core_reset_en, boot_irq_pol, boot_slot_duration} = '0;
    {reg_addr, reg_wdata, ctl_port_addr, scale_port_addr} = '0;
    power_button_pin = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_DEV_CTRL, 8'h10);
    rd(ADDR_DEV_CTRL_TWO, 8'h34);
    rd(8'h55, 8'h00);
    wr(ADDR_DEV_CTRL_TWO, 8'hFF);
    rd(ADDR_DEV_CTRL_TWO, 8'h7F);
    @(posedge clk_sys) irq_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK(irq_out_pin, 1'b1)
    wr(ADDR_DEV_CTRL_TWO, 8'h3C);
    repeat (3) @(posedge clk_sys);
    `CHK(irq_out_pin, 1'b0)
    irq_req <= 1'b0;
    wr(ADDR_DEV_CTRL, 8'h70);
    repeat (2) @(posedge clk_sys);
    `CHK({cal_clk_en, cal_rst}, 2'b01)
    `CHK(slow_clk_rc_sel, 1'b1)
    @(posedge clk_sys) backup_rst <= 1'b1;
    @(posedge clk_sys) backup_rst <= 1'b0;
    rd(ADDR_DEV_CTRL, 8'h50);
    `CHK(slow_clk_rc_sel, 1'b0)
    rd(ADDR_DEV_CTRL_TWO, 8'h34);
    for (int s = 1; s >= 0; s--) begin
      wr(ADDR_DEV_CTRL, 8'(s << 4));
      for (int a = 8'h21; a <= 8'h28; a++) begin
        @(posedge clk_sys) begin
          ctl_port_addr <= 8'(a);
          scale_port_addr <= 8'(a);
        end
        repeat (3) @(posedge clk_sys);
        `CHK(ctl_scale_grant, 1'(s == 1 && a >= 8'h22 && a <= 8'h27))
        `CHK(scale_port_grant, 1'(s == 0 && a >= 8'h22 && a <= 8'h27))
      end
    end
    `CHK({cal_clk_en, cal_rst}, 2'b10)
    {boot_stay_on, boot_slot_duration, boot_hold_core_reset_en, boot_irq_pol} <= 5'b10111;
    @(posedge clk_sys) boot_load <= 1'b1;
    @(posedge clk_sys) boot_load <= 1'b0;
    rd(ADDR_DEV_CTRL, 8'h04);
    rd(ADDR_DEV_CTRL_TWO, 8'h13);
    wr(ADDR_DEV_CTRL, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_DEV_CTRL_TWO, 8'(s << 4));
      pwr_up();
      `CHK({nch, trace}, 20'h4137F)
      `CHK(gap, slot_cyc[s])
      wr(ADDR_DEV_CTRL, 8'h01);
      watch(2'd0);
      `CHK({nch, trace[3:0]}, 8'h10)
      rd(ADDR_DEV_CTRL, 8'h00);
    end
    pwr_up();
    wr(ADDR_DEV_CTRL, 8'h81);
    watch(2'd0);
    `CHK({nch, trace}, 20'h47310)
    rd(ADDR_DEV_CTRL, 8'h80);
    pwr_up();
    wr(ADDR_DEV_CTRL, 8'h08);
    watch(2'd0);
    `CHK(seen, 1'b1)
    rd(ADDR_DEV_CTRL, 8'h00);
    wr(ADDR_DEV_CTRL_TWO, 8'h48);
    pwr_up();
    wr(ADDR_DEV_CTRL, 8'h04);
    ext_off();
    repeat (20) @(posedge clk_sys);
    `CHK(dev_state, 2'd1)
    wr(ADDR_DEV_CTRL, 8'h02);
    repeat (10) @(posedge clk_sys);
    `CHK(dev_state, 2'd1)
    wr(ADDR_DEV_CTRL_TWO, 8'h40);
    watch(2'd2);
    `CHK(dev_state, 2'd2)
    `CHK(buck_use_sleep_level, 1'b1)
    wr(ADDR_DEV_CTRL, 8'h00);
    watch(2'd1);
    `CHK(dev_state, 2'd1)
    `CHK(buck_use_sleep_level, 1'b0)
    ext_off();
    watch(2'd0);
    `CHK(dev_state, 2'd0)
    pwr_up();
    wr(ADDR_DEV_CTRL_TWO, 8'h04);
    press(hit);
    `CHK(hit, 1'b0)
    watch(2'd0);
    `CHK(dev_state, 2'd0)
    wr(ADDR_DEV_CTRL_TWO, 8'h02);
    press(hit);
    `CHK(hit, 1'b1)
    conclude();
  end
  // the sequence needs a few thousand cycles at most
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
